// [hw/hot_swap_pkg.sv]
// constants shared by the hot-swap fault control block
package hot_swap_pkg;

  // clock and breaker timing
  localparam int CLK_PERIOD_PS      = 4000;
  localparam int BREAKER_TIME_NS    = 530000;
  localparam int BREAKER_CYCLES_DEF = (BREAKER_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int BRK_W              = 18;

  // delay units
  localparam logic [1:0] OC_COOL_UNITS = 2'h3;  // last index of four units
  localparam logic [1:0] SETTLE_LAST   = 2'h3;

  // synchronised input positions
  localparam int IN_PERMIT_N = 0;
  localparam int IN_REQUEST  = 1;
  localparam int IN_OC       = 2;
  localparam int IN_SHORT    = 3;
  localparam int IN_OV       = 4;
  localparam int IN_UVH      = 5;
  localparam int IN_UVL      = 6;
  localparam int IN_TICK     = 7;
  localparam int IN_CLAMP    = 8;
  localparam int IN_W        = 9;

  // register byte addresses
  localparam logic [3:0] ADDR_STATUS  = 4'h0;
  localparam logic [3:0] ADDR_FAULT   = 4'h4;
  localparam logic [3:0] ADDR_CONTROL = 4'h8;

  // bit positions used in the status, fault and control words
  localparam int BIT_OV      = 0;
  localparam int BIT_UV      = 1;
  localparam int BIT_OC      = 2;
  localparam int BIT_FET_REQ = 3;
  localparam int BIT_DIS     = 4;
  localparam int BIT_DRIVE   = 7;

  // control values after reset
  localparam logic OV_RETRY_RST = 1'b1;
  localparam logic UV_RETRY_RST = 1'b1;
  localparam logic OC_RETRY_RST = 1'b0;
  localparam logic FET_REQ_RST  = 1'b0;

endpackage

// [hw/hot_swap_fault_control.sv]
// hot-swap on/off, fault latching and retry timing with an avalon-mm register port
`timescale 1ns/1ps
module hot_swap_fault_control
  import hot_swap_pkg::*;
#(
  parameter int BREAKER_CYCLES = BREAKER_CYCLES_DEF
) (
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        permit_n_in,
  input  wire logic        power_request_in,
  input  wire logic        overcurrent_cmp_in,
  input  wire logic        short_cmp_in,
  input  wire logic        surge_sense_input_in,
  input  wire logic        uv_high_input_in,
  input  wire logic        uv_low_input_in,
  input  wire logic        delay_cap_pin_in,
  input  wire logic        ramp_clamp_in,
  input  wire logic        first_seq_in,
  input  wire logic        second_seq_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic             gate_drive_out,
  output logic             current_limit_out,
  output logic             discharge_out,
  output logic             first_good_out_n,
  output logic             second_good_out
);

  typedef struct packed {
    logic [2:0][IN_W-1:0] sync;
    logic [IN_W-1:0]      filt;
    logic [IN_W-1:0]      filt_prev;
    logic [1:0]           settle;
    logic                 ready;
    logic                 dis_fault;
    logic                 fet_req;
    logic                 ov_p;
    logic                 ov_f;
    logic                 ov_r;
    logic                 uv_p;
    logic                 uv_f;
    logic                 uv_r;
    logic                 uv_wait;
    logic                 oc_p;
    logic                 oc_f;
    logic                 oc_r;
    logic                 oc_wait;
    logic [1:0]           oc_units;
    logic                 permit_wait;
    logic [BRK_W-1:0]     brk_cnt;
    logic                 climit;
    logic                 fet_drive;
    logic                 gate;
    logic                 first_good_n;
    logic                 second_good;
    logic                 ack;
    logic [31:0]          rdata;
  } state_t;

  localparam logic [BRK_W-1:0] BRK_LAST = BRK_W'(BREAKER_CYCLES - 1);

  // lockout release is synchronised; assertion of reset stays asynchronous
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  state_t q;
  state_t d;

  logic [IN_W-1:0] raw;
  assign raw = {ramp_clamp_in, delay_cap_pin_in, uv_low_input_in, uv_high_input_in,
                surge_sense_input_in, short_cmp_in, overcurrent_cmp_in,
                power_request_in, permit_n_in};

  function automatic logic rose(input logic now, input logic was);
    rose = now & ~was;
  endfunction

  logic tick;
  logic permit_edge;
  logic permit_fall;
  logic req_rise;
  logic req_fall;
  logic trip;
  logic brk_active;
  logic ok_no_ov;
  logic ov_block;
  logic uv_block;
  logic oc_block;
  logic wr_fault;
  logic wr_ctrl;
  logic clear_all;
  logic [31:0] status_w;
  logic [31:0] fault_w;
  logic [31:0] ctrl_w;

  always_comb begin
    d = q;
    // three-stage synchroniser; stage 0 feeds only stage 1
    d.sync[0] = raw;
    d.sync[1] = q.sync[0];
    d.sync[2] = q.sync[1];
    for (int i = 0; i < IN_W; i++) begin
      if (q.sync[1][i] == q.sync[2][i]) begin
        d.filt[i] = q.sync[2][i];
      end
    end
    d.filt_prev = q.filt;
    // hold off events until the filters hold real pin levels
    if (!q.ready) begin
      d.settle    = q.settle + 2'h1;
      d.ready     = (q.settle == SETTLE_LAST);
      d.filt_prev = d.filt;
    end

    tick        = q.ready & rose(q.filt[IN_TICK], q.filt_prev[IN_TICK]);
    permit_edge = q.ready & (q.filt[IN_PERMIT_N] ^ q.filt_prev[IN_PERMIT_N]);
    permit_fall = permit_edge & ~q.filt[IN_PERMIT_N];
    req_rise    = q.ready & rose(q.filt[IN_REQUEST], q.filt_prev[IN_REQUEST]);
    req_fall    = q.ready & rose(q.filt_prev[IN_REQUEST], q.filt[IN_REQUEST]);

    // register bus: a request is answered one cycle after it appears
    d.ack    = (avs_read_in | avs_write_in) & ~q.ack;
    wr_fault = q.ack & avs_write_in & avs_byteenable_in[0] & (avs_address_in == ADDR_FAULT);
    wr_ctrl  = q.ack & avs_write_in & avs_byteenable_in[0] & (avs_address_in == ADDR_CONTROL);

    // control word
    if (wr_ctrl) begin
      d.ov_r    = avs_writedata_in[BIT_OV];
      d.uv_r    = avs_writedata_in[BIT_UV];
      d.oc_r    = avs_writedata_in[BIT_OC];
      d.fet_req = avs_writedata_in[BIT_FET_REQ];
    end

    // fet request bit: pin edges win over a same-cycle write
    if (permit_fall) begin
      d.permit_wait = 1'b1;
    end else if (q.filt[IN_PERMIT_N]) begin
      d.permit_wait = 1'b0;
    end else if (q.permit_wait && tick) begin
      d.permit_wait = 1'b0;
      if (q.filt[IN_REQUEST]) begin
        d.fet_req = 1'b1;
      end
    end
    if (req_rise) begin
      d.fet_req = 1'b1;
    end else if (req_fall) begin
      d.fet_req = 1'b0;
    end

    clear_all = req_fall | (q.fet_req & ~d.fet_req);

    // host clears of fault bits, refused while the condition is present
    if (wr_fault) begin
      if (!avs_writedata_in[BIT_OV] && !q.ov_p) d.ov_f = 1'b0;
      if (!avs_writedata_in[BIT_UV] && !q.uv_p) d.uv_f = 1'b0;
      if (!avs_writedata_in[BIT_OC] && !q.oc_p) d.oc_f = 1'b0;
      d.dis_fault = avs_writedata_in[BIT_DIS];
    end
    if (clear_all) begin
      d.ov_f      = 1'b0;
      d.uv_f      = 1'b0;
      d.oc_f      = 1'b0;
      d.dis_fault = 1'b0;
    end
    if (permit_edge) begin
      d.dis_fault = 1'b1;
    end

    // overvoltage
    d.ov_p = q.ready & q.filt[IN_OV];
    if (d.ov_p) begin
      d.ov_f = 1'b1;
    end
    ov_block = q.ov_p | (q.ov_f & ~q.ov_r);

    // undervoltage with both-input hysteresis; a reset value of clear lets a
    // supply that is already low log its fault once the filters settle
    if (q.ready && !q.filt[IN_UVH] && !q.filt[IN_UVL]) begin
      d.uv_p = 1'b1;
    end else if (q.uv_p && q.filt[IN_UVH] && q.filt[IN_UVL]) begin
      d.uv_p    = 1'b0;
      d.uv_wait = q.uv_r;
    end
    if (d.uv_p) begin
      d.uv_f = 1'b1;
    end
    if (q.uv_f && !d.uv_f && !q.uv_r && !q.uv_p) begin
      d.uv_wait = 1'b1;
    end
    if (q.uv_wait && tick) begin
      d.uv_wait = 1'b0;
    end
    uv_block = q.uv_p | q.uv_wait | (q.uv_f & ~q.uv_r);

    // breaker counter; the ramp clamp takes over before it can expire
    brk_active = q.ready & q.fet_drive & (q.filt[IN_OC] | q.filt[IN_SHORT]) &
                 ~q.filt[IN_CLAMP];
    d.climit = brk_active;
    trip     = 1'b0;
    if (brk_active) begin
      if (q.brk_cnt == BRK_LAST) begin
        trip      = 1'b1;
        d.brk_cnt = '0;
      end else begin
        d.brk_cnt = q.brk_cnt + BRK_W'(1);
      end
    end else begin
      d.brk_cnt = '0;
    end

    // overcurrent cooling; nothing but its own count ends it
    if (q.oc_wait && tick) begin
      d.oc_units = q.oc_units + 2'h1;
      if (q.oc_units == OC_COOL_UNITS) begin
        d.oc_wait  = 1'b0;
        d.oc_units = 2'h0;
      end
    end
    if (q.oc_p && !q.fet_drive) begin
      d.oc_p = 1'b0;
    end
    if (q.oc_f && !d.oc_f && !q.oc_r && !q.oc_wait) begin
      d.oc_wait  = 1'b1;
      d.oc_units = 2'h0;
    end
    if (trip) begin
      d.oc_p     = 1'b1;
      d.oc_f     = 1'b1;
      d.oc_wait  = 1'b1;
      d.oc_units = 2'h0;
    end
    oc_block = q.oc_p | q.oc_wait | (q.oc_f & ~q.oc_r);

    // drive decision; overvoltage is kept apart so it spares the good outputs
    ok_no_ov    = q.ready & ~q.filt[IN_PERMIT_N] & q.fet_req & ~uv_block & ~oc_block & ~trip;
    d.fet_drive = ok_no_ov & ~ov_block;
    d.gate      = d.fet_drive & ~q.filt[IN_SHORT];
    if (!ok_no_ov) begin
      d.first_good_n = 1'b1;
      d.second_good  = 1'b0;
    end else if (q.fet_drive) begin
      if (first_seq_in) d.first_good_n = 1'b0;
      if (second_seq_in) d.second_good = 1'b1;
    end

    status_w            = '0;
    status_w[BIT_OV]    = q.ov_p;
    status_w[BIT_UV]    = q.uv_p;
    status_w[BIT_OC]    = q.oc_p;
    status_w[BIT_DIS]   = q.filt[IN_PERMIT_N];
    status_w[BIT_DRIVE] = q.fet_drive;
    fault_w             = '0;
    fault_w[BIT_OV]     = q.ov_f;
    fault_w[BIT_UV]     = q.uv_f;
    fault_w[BIT_OC]     = q.oc_f;
    fault_w[BIT_DIS]    = q.dis_fault;
    ctrl_w              = '0;
    ctrl_w[BIT_OV]      = q.ov_r;
    ctrl_w[BIT_UV]      = q.uv_r;
    ctrl_w[BIT_OC]      = q.oc_r;
    ctrl_w[BIT_FET_REQ] = q.fet_req;
    if (avs_read_in && !q.ack) begin
      case (avs_address_in)
        ADDR_STATUS:  d.rdata = status_w;
        ADDR_FAULT:   d.rdata = fault_w;
        ADDR_CONTROL: d.rdata = ctrl_w;
        default:      d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      q              <= '0;
      q.ov_r         <= OV_RETRY_RST;
      q.uv_r         <= UV_RETRY_RST;
      q.oc_r         <= OC_RETRY_RST;
      q.fet_req      <= FET_REQ_RST;
      q.first_good_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~q.ack;
  assign avs_readdata_out    = q.rdata;
  assign gate_drive_out      = q.gate;
  assign current_limit_out   = q.climit;
  assign discharge_out       = ~q.fet_drive;
  assign first_good_out_n    = q.first_good_n;
  assign second_good_out     = q.second_good;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_sync_q);

  a_permit_change_flag: assert property (permit_edge |=> q.dis_fault)
    else $error("permit change did not set disable-change fault");
  a_request_rise_set: assert property (req_rise |=> q.fet_req ##1
    (q.fet_req || !q.filt[IN_REQUEST] || $past(wr_ctrl)))
    else $error("request rise did not set request bit");
  // drive is registered from the previous cycle's terms, so compare against those
  a_drive_and_terms: assert property (q.fet_drive |->
    $past(q.fet_req) && !$past(q.uv_p) && !$past(q.filt[IN_PERMIT_N]))
    else $error("fet driven while a term is false");
  a_breaker_trip_off: assert property (trip |=> !q.fet_drive && q.oc_p && q.oc_f && q.first_good_n)
    else $error("breaker expiry did not turn fet off with oc bits");
  a_oc_present_drop: assert property (q.oc_p && !q.fet_drive && !trip |=> !q.oc_p)
    else $error("overcurrent present stayed after fet off");
  a_oc_cool_hold: assert property (q.oc_wait |=> !q.fet_drive)
    else $error("fet on during cooling");
  a_ov_turn_off: assert property (q.ov_p |=> !q.fet_drive && q.ov_f)
    else $error("overvoltage did not turn fet off");
  a_uv_fault_set: assert property (q.uv_p |-> q.uv_f ##1 !q.fet_drive)
    else $error("undervoltage present without fault or fet off");
  a_breaker_bound: assert property (brk_active && q.brk_cnt == BRK_LAST |=> q.brk_cnt == '0)
    else $error("breaker counter passed its limit");
  a_ov_keeps_good: assert property (ok_no_ov && $past(ok_no_ov) && !q.first_good_n |=> !q.first_good_n)
    else $error("good output dropped without a non-ov cause");

endmodule

// [tb/hot_swap_partner.sv]
// far-side model: pass transistor, sense resistor, supply dividers, delay capacitor
`timescale 1ns/1ps
module hot_swap_partner (
  input  wire logic clk_in,
  input  wire logic gate_in,
  input  wire logic overload_in,
  input  wire logic spike_in,
  input  wire logic surge_in,
  input  wire logic uvh_ok_in,
  input  wire logic uvl_ok_in,
  output logic      oc_cmp_out,
  output logic      short_cmp_out,
  output logic      ov_cmp_out,
  output logic      uvh_out,
  output logic      uvl_out,
  output logic      tick_out
);
  logic [3:0] phase_q = 4'h0;
  // sense current flows only while the transistor conducts, so a trip removes it
  assign oc_cmp_out    = overload_in & gate_in;
  // overshoot events come from the line, not from the gate, so no self-cancelling
  assign short_cmp_out = spike_in;
  assign ov_cmp_out    = surge_in;
  // two dividers move separately so one crossing alone can be shown
  assign uvh_out = uvh_ok_in;
  assign uvl_out = uvl_ok_in;
  // capacitor charge/discharge cycle: one rising edge per delay unit
  always_ff @(posedge clk_in) phase_q <= phase_q + 4'h1;
  assign tick_out = phase_q[3];
endmodule

// [tb/hot_swap_fault_control_tb_top.sv]
// self-checking bench for the hot-swap fault control block
`timescale 1ns/1ps
module hot_swap_fault_control_tb_top;
  import hot_swap_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, permit_n = 1'b1, req = 1'b0, clamp = 1'b0;
  logic seq1 = 1'b1, seq2 = 1'b1, rd = 1'b0, wr = 1'b0;
  logic overload = 1'b0, spike = 1'b0, surge = 1'b0, uvh_ok = 1'b0, uvl_ok = 1'b0;
  logic [3:0]  addr = 4'h0, be = 4'hf;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic        waitreq, gate, climit, dis, good_n, good2, oc, sc, ov, uv_high_input, uv_low_input, tick;
  int          bad_count = 0, checks_done = 0;
  hot_swap_fault_control #(.BREAKER_CYCLES(20)) i_hot_swap_fault_control (
    .sys_clk_in(clk), .arst_n_in(arst_n), .permit_n_in(permit_n),
    .power_request_in(req), .overcurrent_cmp_in(oc), .short_cmp_in(sc),
    .surge_sense_input_in(ov), .uv_high_input_in(uv_high_input), .uv_low_input_in(uv_low_input),
    .delay_cap_pin_in(tick), .ramp_clamp_in(clamp), .first_seq_in(seq1),
    .second_seq_in(seq2), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .gate_drive_out(gate), .current_limit_out(climit),
    .discharge_out(dis), .first_good_out_n(good_n), .second_good_out(good2));
  hot_swap_partner i_hot_swap_partner (
    .clk_in(clk), .gate_in(gate), .overload_in(overload), .spike_in(spike),
    .surge_in(surge), .uvh_ok_in(uvh_ok), .uvl_ok_in(uvl_ok), .oc_cmp_out(oc),
    .short_cmp_out(sc), .ov_cmp_out(ov), .uvh_out(uv_high_input), .uvl_out(uv_low_input), .tick_out(tick));
  initial begin
    forever #2 clk = ~clk;
  end
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // one avalon access; waitrequest and read data are taken at the rising edge
  task bus(input logic w, input logic [3:0] a, input logic [31:0] wd,
           output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a; wdata <= wd; wr <= w; rd <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) chk(1, 0, "bus hang");
    d = rdata;
    rd <= 1'b0; wr <= 1'b0;
  endtask
  task rdcmp(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] d;
    bus(1'b0, a, 32'h0000_0000, d);
    chk(d, {24'h00_0000, e}, "register");
  endtask
  // upper bits are random: only bits 7:0 carry meaning
  task wrb(input logic [3:0] a, input logic [7:0] v);
    logic [31:0] d, r;
    r = $urandom;
    bus(1'b1, a, {r[23:0], v}, d);
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task wait_gate(input logic v, input int lim);
    int n;
    n = 0;
    while (gate !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(gate, v, "gate");
  endtask
  task done(input string t);
    $display("test %s finished", t);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude;
  end
  initial begin
    void'($urandom(32'h9188));
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    cyc(20);
    rdcmp(ADDR_CONTROL, 8'h03);
    rdcmp(ADDR_FAULT, 8'h02);
    rdcmp(ADDR_STATUS, 8'h12);
    rdcmp(4'hC, 8'h00);
    done("lockout");
    @(posedge clk) uvh_ok <= 1'b1;
    cyc(20);
    rdcmp(ADDR_STATUS, 8'h12);
    wrb(ADDR_FAULT, 8'h00);
    rdcmp(ADDR_FAULT, 8'h02);
    @(posedge clk) uvl_ok <= 1'b1;
    cyc(20);
    rdcmp(ADDR_STATUS, 8'h10);
    wrb(ADDR_FAULT, 8'h00);
    rdcmp(ADDR_FAULT, 8'h00);
    done("uv inputs");
    @(posedge clk) permit_n <= 1'b0;
    cyc(20);
    rdcmp(ADDR_STATUS, 8'h00);
    rdcmp(ADDR_FAULT, 8'h10);
    @(posedge clk) req <= 1'b1;
    cyc(20);
    rdcmp(ADDR_CONTROL, 8'h0B);
    wait_gate(1'b1, 400);
    rdcmp(ADDR_STATUS, 8'h80);
    chk(good_n, 1'b0, "good");
    chk(good2, 1'b1, "good2");
    done("turn on");
    @(posedge clk) begin clamp <= 1'b1; overload <= 1'b1; end
    cyc(60);
    chk(gate, 1'b1, "clamp gate");
    chk(climit, 1'b0, "clamp limit");
    chk(good_n, 1'b0, "clamp good");
    rdcmp(ADDR_FAULT, 8'h10);
    @(posedge clk) clamp <= 1'b0;
    cyc(8);
    chk(climit, 1'b1, "limit");
    wait_gate(1'b0, 60);
    cyc(5);
    chk(good_n, 1'b1, "oc good");
    chk(good2, 1'b0, "oc good2");
    chk(dis, 1'b1, "oc discharge");
    rdcmp(ADDR_STATUS, 8'h00);
    rdcmp(ADDR_FAULT, 8'h14);
    cyc(150);
    chk(gate, 1'b0, "latched");
    wrb(ADDR_FAULT, 8'h10);
    cyc(30);
    chk(gate, 1'b0, "cooling");
    wait_gate(1'b1, 200);
    @(posedge clk) overload <= 1'b0;
    done("overcurrent");
    @(posedge clk) surge <= 1'b1;
    wait_gate(1'b0, 10);
    cyc(10);
    chk(dis, 1'b1, "ov discharge");
    chk(good_n, 1'b0, "ov good");
    chk(good2, 1'b1, "ov good2");
    rdcmp(ADDR_STATUS, 8'h01);
    rdcmp(ADDR_FAULT, 8'h11);
    @(posedge clk) surge <= 1'b0;
    wait_gate(1'b1, 12);
    done("overvoltage");
    @(posedge clk) spike <= 1'b1;
    wait_gate(1'b0, 8);
    @(posedge clk) spike <= 1'b0;
    wait_gate(1'b1, 12);
    rdcmp(ADDR_FAULT, 8'h11);
    done("short");
    @(posedge clk) begin uvh_ok <= 1'b0; uvl_ok <= 1'b0; end
    wait_gate(1'b0, 10);
    cyc(5);
    chk(good_n, 1'b1, "uv good");
    chk(good2, 1'b0, "uv good2");
    rdcmp(ADDR_STATUS, 8'h02);
    rdcmp(ADDR_FAULT, 8'h13);
    @(posedge clk) begin uvh_ok <= 1'b1; uvl_ok <= 1'b1; end
    wait_gate(1'b1, 60);
    done("undervoltage");
    @(posedge clk) req <= 1'b0;
    cyc(20);
    rdcmp(ADDR_CONTROL, 8'h03);
    rdcmp(ADDR_FAULT, 8'h00);
    chk(gate, 1'b0, "request off");
    wrb(ADDR_CONTROL, 8'h0F);
    wrb(ADDR_FAULT, 8'h10);
    rdcmp(ADDR_CONTROL, 8'h0F);
    rdcmp(ADDR_FAULT, 8'h10);
    wrb(ADDR_CONTROL, 8'h07);
    rdcmp(ADDR_FAULT, 8'h00);
    done("host control");
    @(posedge clk) permit_n <= 1'b1;
    cyc(20);
    rdcmp(ADDR_STATUS, 8'h10);
    rdcmp(ADDR_FAULT, 8'h10);
    @(posedge clk) req <= 1'b1;
    cyc(20);
    wrb(ADDR_CONTROL, 8'h07);
    rdcmp(ADDR_CONTROL, 8'h07);
    @(posedge clk) permit_n <= 1'b0;
    cyc(60);
    rdcmp(ADDR_CONTROL, 8'h0F);
    rdcmp(ADDR_FAULT, 8'h10);
    done("permit delay");
    conclude;
  end
endmodule
